/* File: verilog/irq_event_map.svh */
// Purpose: register offsets, bit positions and masks of the event block
// Assumes: offsets are byte addresses inside the host base region
// Notes: definitions only
`ifndef IRQ_EVENT_MAP_SVH
`define IRQ_EVENT_MAP_SVH

`define OFS_EVENT_SET 8'h80
`define OFS_EVENT_CLR 8'h84
`define OFS_MASK_SET 8'h88
`define OFS_MASK_CLR 8'h8C

`define BIT_BUS_REINIT 17
`define BIT_IDENT_DONE 16
`define BIT_ATOMIC_FAIL 9
`define BIT_BUFWR_FAIL 8
`define BIT_STREAM_RX 7
`define BIT_STREAM_TX 6
`define BIT_RX_REPLY_PKT 5
`define BIT_RX_REQ_PKT 4
`define BIT_RX_REPLY_BUF 3
`define BIT_RX_REQ_BUF 2
`define BIT_TX_REPLY_DONE 1
`define BIT_TX_REQ_DONE 0
`define BIT_GLOBAL_EN 31

`define EVENT_LATCH_BITS 32'h0003_033F
`define EVENT_READ_BITS 32'h0003_03FF
`define MASK_IMPL_BITS 32'h8003_03FF
`define EVENT_RESET 32'h0000_0000
`define MASK_RESET 32'h0000_0000

`endif

/* File: verilog/irq_event_pkg.sv */
// Purpose: types shared by the event block and its users
// Assumes: nothing
// Notes: offsets live in irq_event_map.svh
package irq_event_pkg;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [47:0] dest_offset;
    logic [15:0] source_id;
  } write_fail_info_t;

endpackage

/* File: verilog/rise_detect.sv */
// Purpose: per-bit asserting edge detector
// Assumes: inputs already on sys_clk
// Notes: rise is combinational from the held previous level
`timescale 1ns/1ps
`default_nettype none
module rise_detect #(
  parameter int W = 32
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] level,
  output logic [W-1:0] rise
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic prev_q;
      always_ff @(posedge sys_clk) begin
        if (!rst_b) prev_q <= 1'b0;
        else prev_q <= level[i];
      end
      assign rise[i] = level[i] & ~prev_q;
    end
  endgenerate
endmodule // rise_detect
`default_nettype wire

/* File: verilog/masked_any.sv */
// Purpose: or of a masked event vector
// Assumes: purely combinational
// Notes: used for the stream context summaries
`timescale 1ns/1ps
`default_nettype none
module masked_any #(
  parameter int W = 8
) (
  input wire logic [W-1:0] events,
  input wire logic [W-1:0] mask,
  output logic any
);
  assign any = |(events & mask);
endmodule // masked_any
`default_nettype wire

/* File: verilog/host_interrupt_event_mask.sv */
// Purpose: host interrupt event and mask registers, one interrupt request
// Assumes: all sources are levels on sys_clk; register port as documented
// Notes: upper event bits not held here and read as zero
`timescale 1ns/1ps
`default_nettype none
`include "irq_event_map.svh"
module host_interrupt_event_mask #(
  parameter int CTX = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire irq_event_pkg::reg_req_t reg_req,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic bus_reinit_src,
  input wire logic node_ident_phase,
  input wire logic node_ident_done_src,
  input wire logic accept_node_ident_packets,
  input wire logic atomic_reply_fail_src,
  input wire logic buffered_write_fail_src,
  input wire irq_event_pkg::write_fail_info_t write_fail_in,
  output irq_event_pkg::write_fail_info_t write_fail_info,
  input wire logic rx_reply_packet_src,
  input wire logic rx_request_packet_src,
  input wire logic rx_reply_buffer_src,
  input wire logic rx_reply_buffer_irq,
  input wire logic rx_request_buffer_src,
  input wire logic rx_request_buffer_irq,
  input wire logic tx_reply_done_src,
  input wire logic tx_reply_done_irq,
  input wire logic tx_request_done_src,
  input wire logic tx_request_done_irq,
  input wire logic [CTX-1:0] stream_rx_ctx_events,
  input wire logic [CTX-1:0] stream_rx_ctx_mask,
  input wire logic [CTX-1:0] stream_tx_ctx_events,
  input wire logic [CTX-1:0] stream_tx_ctx_mask,
  output logic irq_req
);
  import irq_event_pkg::*;

  logic [31:0] irq_event_reg_q;
  logic [31:0] irq_event_reg_d;
  logic [31:0] irq_mask_reg_q;
  logic [31:0] irq_mask_reg_d;
  logic [31:0] reg_rdata_q;
  logic [31:0] reg_rdata_d;
  logic reg_rvalid_q;
  write_fail_info_t write_fail_q;

  // source levels, one per latched bit
  logic [31:0] src_lvl;
  logic [31:0] src_rise;

  always_comb begin
    src_lvl = 32'h0000_0000;
    src_lvl[`BIT_BUS_REINIT] = bus_reinit_src;
    src_lvl[`BIT_IDENT_DONE] = node_ident_done_src
      & accept_node_ident_packets;
    src_lvl[`BIT_ATOMIC_FAIL] = atomic_reply_fail_src;
    src_lvl[`BIT_BUFWR_FAIL] = buffered_write_fail_src;
    src_lvl[`BIT_RX_REPLY_PKT] = rx_reply_packet_src;
    src_lvl[`BIT_RX_REQ_PKT] = rx_request_packet_src;
    src_lvl[`BIT_RX_REPLY_BUF] = rx_reply_buffer_src
      & rx_reply_buffer_irq;
    src_lvl[`BIT_RX_REQ_BUF] = rx_request_buffer_src
      & rx_request_buffer_irq;
    src_lvl[`BIT_TX_REPLY_DONE] = tx_reply_done_src
      & tx_reply_done_irq;
    src_lvl[`BIT_TX_REQ_DONE] = tx_request_done_src
      & tx_request_done_irq;
  end

  rise_detect #(
    .W(32)
  ) u_rise (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .level(src_lvl),
    .rise(src_rise)
  );

  // stream context summaries, never latched
  logic stream_rx_any;
  logic stream_tx_any;

  masked_any #(
    .W(CTX)
  ) u_rx_any (
    .events(stream_rx_ctx_events),
    .mask(stream_rx_ctx_mask),
    .any(stream_rx_any)
  );

  masked_any #(
    .W(CTX)
  ) u_tx_any (
    .events(stream_tx_ctx_events),
    .mask(stream_tx_ctx_mask),
    .any(stream_tx_any)
  );

  // register port decode
  wire wr_ev_set = reg_req.wr && (reg_req.addr == `OFS_EVENT_SET);
  wire wr_ev_clr = reg_req.wr && (reg_req.addr == `OFS_EVENT_CLR);
  wire wr_mk_set = reg_req.wr && (reg_req.addr == `OFS_MASK_SET);
  wire wr_mk_clr = reg_req.wr && (reg_req.addr == `OFS_MASK_CLR);

  wire [31:0] latch_bits = `EVENT_LATCH_BITS;
  wire [31:0] mask_bits = `MASK_IMPL_BITS;

  // software set and clear vectors
  wire [31:0] ev_sw_set = wr_ev_set ? reg_req.wdata : 32'h0000_0000;
  wire [31:0] ev_sw_clr_raw = wr_ev_clr ? reg_req.wdata : 32'h0000_0000;
  wire hold_reinit = node_ident_phase;
  wire [31:0] hold_vec = {14'h0000, hold_reinit, 17'h0_0000};
  wire [31:0] ev_sw_clr = ev_sw_clr_raw & ~hold_vec;

  wire [31:0] ev_set_all = (src_rise | ev_sw_set) & latch_bits;
  wire reinit_set = ev_set_all[`BIT_BUS_REINIT];

  // live view of the event register
  wire [31:0] summary_vec = {24'h00_0000, stream_rx_any, stream_tx_any,
    6'h00};
  wire [31:0] event_view = (irq_event_reg_q & latch_bits) | summary_vec;
  wire [31:0] event_masked = event_view & irq_mask_reg_q;

  always_comb begin
    irq_event_reg_d = ((irq_event_reg_q & ~ev_sw_clr) | ev_set_all)
      & latch_bits;
    if (reinit_set) begin
      irq_event_reg_d[`BIT_IDENT_DONE] = 1'b0;
    end
  end

  always_comb begin
    irq_mask_reg_d = irq_mask_reg_q;
    if (wr_mk_set) begin
      irq_mask_reg_d = irq_mask_reg_q | (reg_req.wdata & mask_bits);
    end else if (wr_mk_clr) begin
      irq_mask_reg_d = irq_mask_reg_q & ~(reg_req.wdata & mask_bits);
    end
  end

  // read decode
  wire rd_ev_set = reg_req.rd && (reg_req.addr == `OFS_EVENT_SET);
  wire rd_ev_clr = reg_req.rd && (reg_req.addr == `OFS_EVENT_CLR);
  wire rd_mask = reg_req.rd && ((reg_req.addr == `OFS_MASK_SET)
    || (reg_req.addr == `OFS_MASK_CLR));

  always_comb begin
    if (rd_ev_set) begin
      reg_rdata_d = event_view;
    end else if (rd_ev_clr) begin
      reg_rdata_d = event_masked;
    end else if (rd_mask) begin
      reg_rdata_d = irq_mask_reg_q & mask_bits;
    end else begin
      reg_rdata_d = 32'h0000_0000;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      irq_event_reg_q <= `EVENT_RESET;
      irq_mask_reg_q <= `MASK_RESET;
      reg_rdata_q <= 32'h0000_0000;
      reg_rvalid_q <= 1'b0;
    end else begin
      irq_event_reg_q <= irq_event_reg_d;
      irq_mask_reg_q <= irq_mask_reg_d;
      reg_rdata_q <= reg_rdata_d;
      reg_rvalid_q <= reg_req.rd;
    end
  end

  // failure details caught with the edge
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      write_fail_q <= '0;
    end else if (src_rise[`BIT_BUFWR_FAIL]) begin
      write_fail_q <= write_fail_in;
    end
  end

  wire global_en = irq_mask_reg_q[`BIT_GLOBAL_EN];

  assign irq_req = global_en && (|event_masked[30:0]);
  assign reg_rdata = reg_rdata_q;
  assign reg_rvalid = reg_rvalid_q;
  assign write_fail_info = write_fail_q;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_read(logic [7:0] a);
    reg_req.rd && (reg_req.addr == a);
  endsequence

  sequence s_write(logic [7:0] a);
    reg_req.wr && (reg_req.addr == a);
  endsequence

  property p_reinit_sets;
    src_rise[`BIT_BUS_REINIT] |=> irq_event_reg_q[`BIT_BUS_REINIT]
      && !irq_event_reg_q[`BIT_IDENT_DONE];
  endproperty
  a_reinit_sets: assert property (p_reinit_sets)
    else $error("bus reset event not set or ident bit kept");

  property p_ident_gated;
    $rose(node_ident_done_src) && !src_rise[`BIT_BUS_REINIT]
      |=> irq_event_reg_q[`BIT_IDENT_DONE] == $past(accept_node_ident_packets)
      || $past(irq_event_reg_q[`BIT_IDENT_DONE]) || $past(wr_ev_set);
  endproperty
  a_ident_gated: assert property (p_ident_gated)
    else $error("ident done event ignores its enable");

  property p_reinit_held;
    node_ident_phase && irq_event_reg_q[`BIT_BUS_REINIT]
      |=> irq_event_reg_q[`BIT_BUS_REINIT];
  endproperty
  a_reinit_held: assert property (p_reinit_held)
    else $error("bus reset event cleared during ident phase");

  property p_edge_latch;
    $rose(atomic_reply_fail_src) ##1 (!wr_ev_clr)[*2]
      |-> irq_event_reg_q[`BIT_ATOMIC_FAIL];
  endproperty
  a_edge_latch: assert property (p_edge_latch)
    else $error("atomic reply failure not latched");

  property p_fail_capture;
    $rose(buffered_write_fail_src) |=> irq_event_reg_q[`BIT_BUFWR_FAIL]
      && write_fail_info == $past(write_fail_in);
  endproperty
  a_fail_capture: assert property (p_fail_capture)
    else $error("write failure details not captured");

  property p_rx_summary;
    s_read(`OFS_EVENT_SET) |=> reg_rdata[`BIT_STREAM_RX]
      == $past(|(stream_rx_ctx_events & stream_rx_ctx_mask));
  endproperty
  a_rx_summary: assert property (p_rx_summary)
    else $error("rx summary bit wrong on read");

  property p_tx_summary;
    s_read(`OFS_EVENT_SET) |=> reg_rdata[`BIT_STREAM_TX]
      == $past(|(stream_tx_ctx_events & stream_tx_ctx_mask));
  endproperty
  a_tx_summary: assert property (p_tx_summary)
    else $error("tx summary bit wrong on read");

  property p_mask_set;
    s_write(`OFS_MASK_SET) |=> ((irq_mask_reg_q & $past(reg_req.wdata)
      & mask_bits) == ($past(reg_req.wdata) & mask_bits));
  endproperty
  a_mask_set: assert property (p_mask_set)
    else $error("mask set write lost");

  property p_mask_clr;
    s_write(`OFS_MASK_CLR) |=> (irq_mask_reg_q & $past(reg_req.wdata))
      == 32'h0000_0000;
  endproperty
  a_mask_clr: assert property (p_mask_clr)
    else $error("mask clear write lost");

  property p_no_global;
    !irq_mask_reg_q[`BIT_GLOBAL_EN] |-> !irq_req;
  endproperty
  a_no_global: assert property (p_no_global)
    else $error("interrupt without global enable");

  property p_masked_read;
    s_read(`OFS_EVENT_CLR) |=> reg_rvalid
      && reg_rdata == ($past(event_view) & $past(irq_mask_reg_q));
  endproperty
  a_masked_read: assert property (p_masked_read)
    else $error("masked event read wrong");

  property p_reset_global;
    disable iff (1'b0)
    !rst_b |=> !irq_mask_reg_q[`BIT_GLOBAL_EN] && !irq_req;
  endproperty
  a_reset_global: assert property (p_reset_global)
    else $error("global enable survived reset");

  property p_ev_set_write;
    s_write(`OFS_EVENT_SET) && reg_req.wdata[`BIT_TX_REQ_DONE]
      |=> irq_event_reg_q[`BIT_TX_REQ_DONE] ##1 irq_req
      || !irq_mask_reg_q[`BIT_GLOBAL_EN] || !irq_mask_reg_q[`BIT_TX_REQ_DONE]
      || !irq_event_reg_q[`BIT_TX_REQ_DONE];
  endproperty
  a_ev_set_write: assert property (p_ev_set_write)
    else $error("event set write failed to raise interrupt");

  property p_reserved_zero;
    reg_req.rd |=> (reg_rdata & ~mask_bits) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  property p_set_wins;
    src_rise[`BIT_RX_REQ_PKT] && wr_ev_clr && reg_req.wdata[`BIT_RX_REQ_PKT]
      |=> irq_event_reg_q[`BIT_RX_REQ_PKT];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("event lost to a clear in the same cycle");

  property p_level_once;
    $past(rst_b) |=> (irq_event_reg_q & ~$past(irq_event_reg_q) & ~$past(ev_sw_set)
      & ~($past(src_lvl) & ~$past(src_lvl, 2))) == 32'h0000_0000;
  endproperty
  a_level_once: assert property (p_level_once)
    else $error("event set without a rising source");

endmodule // host_interrupt_event_mask
`default_nettype wire

/* File: tb/host_sw_model.sv */
// Purpose: host software side, one register word access at a time
// Assumes: requests change 1 ns after the rising edge
// Notes: read data is taken with reg_rvalid, one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module host_sw_model (
  input wire logic sys_clk,
  output var irq_event_pkg::reg_req_t reg_req,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid
);
  import irq_event_pkg::*;
  initial reg_req = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    #1 reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    #1 reg_req = '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    #1 reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge sys_clk);
    #1 d = reg_rvalid ? reg_rdata : 32'hxxxx_xxxx;
    reg_req = '0;
  endtask
endmodule // host_sw_model
`default_nettype wire

/* File: tb/host_interrupt_event_mask_tb.sv */
// Purpose: self-checking bench of the event and mask block
// Assumes: host_sw_model drives the register port
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "irq_event_map.svh"
module host_interrupt_event_mask_tb;
  import irq_event_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  reg_req_t req;
  logic [31:0] rdata, r;
  logic rvalid, irq;
  logic [17:0] s = '0;
  logic [3:0] q = '0;
  logic ph = 1'b0;
  logic acc = 1'b0;
  logic [7:0] rxe = '0, rxm = '0, txe = '0, txm = '0;
  write_fail_info_t wfi = '{48'h1234_5678_9ABC, 16'hFFC2};
  write_fail_info_t wfo;
  int bl[8] = '{0, 1, 2, 3, 4, 5, 8, 9};
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #10 sys_clk = ~sys_clk;
  host_sw_model host (.sys_clk(sys_clk), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid));
  host_interrupt_event_mask #(.CTX(8)) dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
    .bus_reinit_src(s[17]), .node_ident_phase(ph), .node_ident_done_src(s[16]),
    .accept_node_ident_packets(acc), .atomic_reply_fail_src(s[9]),
    .buffered_write_fail_src(s[8]), .write_fail_in(wfi), .write_fail_info(wfo),
    .rx_reply_packet_src(s[5]), .rx_request_packet_src(s[4]),
    .rx_reply_buffer_src(s[3]), .rx_reply_buffer_irq(q[3]),
    .rx_request_buffer_src(s[2]), .rx_request_buffer_irq(q[2]),
    .tx_reply_done_src(s[1]), .tx_reply_done_irq(q[1]),
    .tx_request_done_src(s[0]), .tx_request_done_irq(q[0]),
    .stream_rx_ctx_events(rxe), .stream_rx_ctx_mask(rxm),
    .stream_tx_ctx_events(txe), .stream_tx_ctx_mask(txm), .irq_req(irq));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    host.rd(a, r);
    chk(r, e);
  endtask
  task automatic pulse(input int b);
    @(posedge sys_clk);
    #1 s[b] = 1'b1;
    @(posedge sys_clk);
    #1 s[b] = 1'b0;
  endtask
  task automatic t_edges();
    q = 4'hF;
    foreach (bl[i]) begin
      host.wr(`OFS_EVENT_CLR, 32'hFFFF_FFFF);
      pulse(bl[i]);
      rchk(`OFS_EVENT_SET, 32'h1 << bl[i]);
    end
    chk(wfo[63:32], wfi[63:32]);
    chk(wfo[31:0], wfi[31:0]);
    host.wr(`OFS_EVENT_CLR, 32'hFFFF_FFFF);
    q = 4'h0;
    for (int b = 0; b < 4; b++) pulse(b);
    rchk(`OFS_EVENT_SET, 32'h0000_0000);
    s[4] = 1'b1;
    repeat (3) @(posedge sys_clk);
    host.wr(`OFS_EVENT_CLR, 32'h0000_0010);
    rchk(`OFS_EVENT_SET, 32'h0000_0000);
    s[4] = 1'b0;
    fork
      host.wr(`OFS_EVENT_CLR, 32'h0000_0010);
      pulse(4);
    join
    rchk(`OFS_EVENT_SET, 32'h0000_0010);
    host.wr(`OFS_EVENT_CLR, 32'h0000_0010);
  endtask
  task automatic t_bus();
    pulse(16);
    rchk(`OFS_EVENT_SET, 32'h0000_0000);
    acc = 1'b1;
    pulse(16);
    rchk(`OFS_EVENT_SET, 32'h0001_0000);
    ph = 1'b1;
    pulse(17);
    rchk(`OFS_EVENT_SET, 32'h0002_0000);
    host.wr(`OFS_EVENT_CLR, 32'h0002_0000);
    rchk(`OFS_EVENT_SET, 32'h0002_0000);
    ph = 1'b0;
    // ident phase over before the clear
    host.wr(`OFS_EVENT_CLR, 32'h0002_0000);
    rchk(`OFS_EVENT_SET, 32'h0000_0000);
  endtask
  task automatic t_stream();
    rxe = 8'h10;
    rxm = 8'h01;
    rchk(`OFS_EVENT_SET, 32'h0000_0000);
    rxm = 8'h11;
    rchk(`OFS_EVENT_SET, 32'h0000_0080);
    txe = 8'h80;
    txm = 8'h80;
    host.wr(`OFS_EVENT_CLR, 32'h0000_00C0);
    rchk(`OFS_EVENT_SET, 32'h0000_00C0);
    rxe = 8'h00;
    txm = 8'h00;
    rchk(`OFS_EVENT_SET, 32'h0000_0000);
    host.wr(`OFS_EVENT_SET, 32'hFFFF_FFFF);
    rchk(`OFS_EVENT_SET, 32'h0002_033F);
    host.wr(`OFS_EVENT_CLR, 32'hFFFF_FFFF);
    rchk(`OFS_EVENT_SET, 32'h0000_0000);
  endtask
  task automatic t_mask();
    host.wr(`OFS_MASK_SET, 32'hFFFF_FFFF);
    rchk(`OFS_MASK_SET, `MASK_IMPL_BITS);
    host.wr(`OFS_MASK_CLR, 32'h8000_0000);
    host.wr(`OFS_EVENT_SET, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rchk(`OFS_EVENT_CLR, 32'h0000_0001);
    host.wr(`OFS_MASK_SET, 32'h8000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    host.wr(`OFS_MASK_CLR, 32'h0000_0001);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
    rchk(`OFS_MASK_CLR, 32'h8003_03FE);
    rchk(8'h40, 32'h0000_0000);
    rxe = 8'h01;
    rxm = 8'h01;
    rchk(`OFS_EVENT_CLR, 32'h0000_0080);
    chk({31'h0000_0000, irq}, 32'h0000_0001);
    rxe = 8'h00;
    @(posedge sys_clk);
    #1 rst_b = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    rchk(`OFS_MASK_SET, 32'h0000_0000);
    chk({31'h0000_0000, irq}, 32'h0000_0000);
  endtask
  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      $display("mismatch t=%0t timeout", $time);
      print_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    rchk(`OFS_MASK_SET, 32'h0000_0000);
    t_edges();
    t_bus();
    t_stream();
    t_mask();
    print_verdict();
  end
endmodule // host_interrupt_event_mask_tb
`default_nettype wire
